// ### logic/alsup_top.sv
// Purpose: controller-side supervision of the alarm ring
// Assumes: field devices keep their own isolation behaviour
// Notes: ring path healing is done by the field devices
`timescale 1ns/100ps
module alsup_top #(
  parameter int unsigned LOGIC_CYC = alsup_pkg::LOGIC_PERIOD_CYC,
  parameter int unsigned STAMP_CYC = alsup_pkg::TIME_STAMP_CYC,
  parameter int unsigned OFFLINE_CYC = alsup_pkg::OFFLINE_CYC,
  parameter int unsigned RING_CYC = alsup_pkg::RING_TIMEOUT_CYC,
  parameter int unsigned NPAGE = alsup_pkg::N_PAGE
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw conditions
  input wire logic [7:0] fault_in,
  input wire logic [7:0] alarm_in,
  input wire logic reset_button,
  // ring heartbeat
  output logic hb_send_a,
  output logic hb_send_b,
  output logic hb_stamp,
  input wire logic hb_echo_a,
  input wire logic hb_echo_b,
  // field device status
  input wire logic [7:0] dev_config,
  input wire logic [7:0] dev_report,
  // annunciation
  output logic [7:0] fault_led,
  output logic [7:0] alarm_led,
  output logic [7:0] dev_offline,
  output logic trouble_tone,
  output logic alarm_tone,
  output logic trouble_relay,
  // user logic evaluator
  output logic page_go,
  output logic [3:0] page_num,
  input wire logic page_done,
  output logic cycle_start,
  // log read
  input wire logic [11:0] log_raddr,
  output logic [15:0] log_rdata,
  output logic [11:0] log_count
);
  alsup_log_if lg ();

  logic [7:0] flt_reg, flt_next, alm_reg, alm_next, off_reg;
  wire logic [7:0] off_next;
  logic [7:0] flt_raw, flt_rise, alm_rise, flt_prev_reg, alm_prev_reg;
  logic btn_prev_reg, rst_ok, rst_take;
  logic [31:0] off_cnt_reg [8];
  logic [31:0] off_cnt_next [8];
  logic [31:0] ring_cnt_reg, ring_cnt_next;
  logic ring_flt_reg, ring_flt_next;
  logic [31:0] cyc_cnt_reg, cyc_cnt_next, st_cnt_reg, st_cnt_next;
  logic tick, stamp_tick;
  alsup_pkg::alsup_logic_state_t ls_reg, ls_next;
  logic [3:0] pg_reg, pg_next;

  // per-device offline watchdog
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dev
      always_comb begin
        off_cnt_next[gi] = off_cnt_reg[gi];
        if (!dev_config[gi] || dev_report[gi]) begin
          off_cnt_next[gi] = 32'h0;
        end else if (off_cnt_reg[gi] < OFFLINE_CYC) begin
          off_cnt_next[gi] = off_cnt_reg[gi] + 32'h1;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          off_cnt_reg[gi] <= 32'h0;
        end else begin
          off_cnt_reg[gi] <= off_cnt_next[gi];
        end
      end
      assign off_next[gi] = dev_config[gi] && off_cnt_reg[gi] >= OFFLINE_CYC;
    end
  endgenerate

  // ring continuity: each port must hear the other side's heartbeat
  always_comb begin
    ring_cnt_next = ring_cnt_reg + 32'h1;
    ring_flt_next = ring_flt_reg;
    if (hb_echo_a && hb_echo_b) begin
      ring_cnt_next = 32'h0;
      ring_flt_next = 1'b0;
    end else if (ring_cnt_reg >= RING_CYC) begin
      ring_cnt_next = ring_cnt_reg;
      ring_flt_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ring_cnt_reg <= 32'h0;
      ring_flt_reg <= 1'b0;
      off_reg <= 8'h00;
    end else begin
      ring_cnt_reg <= ring_cnt_next;
      ring_flt_reg <= ring_flt_next;
      off_reg <= off_next;
    end
  end

  // live fault conditions: external plus ring and offline
  always_comb begin
    flt_raw = fault_in;
    flt_raw[alsup_pkg::FLT_RING] = fault_in[alsup_pkg::FLT_RING] | ring_flt_reg;
    flt_raw[alsup_pkg::FLT_OFFLINE] = fault_in[alsup_pkg::FLT_OFFLINE] | (|off_reg);
  end

  // reset only when every shown condition is inactive
  assign rst_ok = (flt_raw == 8'h00) && (alarm_in == 8'h00);
  assign rst_take = reset_button && !btn_prev_reg && rst_ok;
  assign flt_rise = flt_raw & ~flt_prev_reg;
  assign alm_rise = alarm_in & ~alm_prev_reg;

  // latched indications; new conditions win over a reset
  always_comb begin
    flt_next = flt_reg | flt_raw;
    alm_next = alm_reg | alarm_in;
    if (rst_take) begin
      flt_next = flt_raw;
      alm_next = alarm_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flt_reg <= 8'h00;
      alm_reg <= 8'h00;
      flt_prev_reg <= 8'h00;
      alm_prev_reg <= 8'h00;
      btn_prev_reg <= 1'b0;
    end else begin
      flt_reg <= flt_next;
      alm_reg <= alm_next;
      flt_prev_reg <= flt_raw;
      alm_prev_reg <= alarm_in;
      btn_prev_reg <= reset_button;
    end
  end

  // annunciation outputs
  assign fault_led = flt_reg;
  assign alarm_led = alm_reg;
  assign dev_offline = off_reg;
  assign trouble_tone = |flt_reg;
  assign trouble_relay = ~(|flt_reg);
  assign alarm_tone = |alm_reg;

  // heartbeat out both directions, stamp pulse each second
  assign hb_send_a = ~rst;
  assign hb_send_b = ~rst;
  assign hb_stamp = stamp_tick;

  // logic cycle and time stamp timers
  always_comb begin
    tick = cyc_cnt_reg == LOGIC_CYC - 1;
    cyc_cnt_next = tick ? 32'h0 : cyc_cnt_reg + 32'h1;
    stamp_tick = st_cnt_reg == STAMP_CYC - 1;
    st_cnt_next = stamp_tick ? 32'h0 : st_cnt_reg + 32'h1;
  end

  // page sequencer
  always_comb begin
    ls_next = ls_reg;
    pg_next = pg_reg;
    case (ls_reg)
      alsup_pkg::ALSUP_IDLE: begin
        if (tick) begin
          ls_next = alsup_pkg::ALSUP_RUN;
          pg_next = 4'h0;
        end
      end
      alsup_pkg::ALSUP_RUN: begin
        if (page_done) begin
          if (pg_reg == 4'(NPAGE - 1)) begin
            ls_next = alsup_pkg::ALSUP_DONE;
          end else begin
            pg_next = pg_reg + 4'h1;
          end
        end
      end
      alsup_pkg::ALSUP_DONE: begin
        if (tick) begin
          ls_next = alsup_pkg::ALSUP_RUN;
          pg_next = 4'h0;
        end
      end
      default: ls_next = alsup_pkg::ALSUP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_cnt_reg <= 32'h0;
      st_cnt_reg <= 32'h0;
      ls_reg <= alsup_pkg::ALSUP_IDLE;
      pg_reg <= 4'h0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_next;
      st_cnt_reg <= st_cnt_next;
      ls_reg <= ls_next;
      pg_reg <= pg_next;
    end
  end

  // a run that spills past a tick simply keeps going
  assign page_go = ls_reg == alsup_pkg::ALSUP_RUN;
  assign page_num = pg_reg;
  assign cycle_start = tick;

  // event log: record each new fault or alarm; when both rise in one cycle only the faults are recorded
  always_comb begin
    lg.wr = (|flt_rise) || (|alm_rise);
    lg.wdata = (|flt_rise) ? {7'h00, 1'b0, flt_rise} : {7'h00, 1'b1, alm_rise};
    lg.raddr = log_raddr;
  end

  alsup_log #(.DEPTH(alsup_pkg::LOG_DEPTH)) u_log (
    .clk(clk),
    .rst(rst),
    .lg(lg)
  );

  assign log_rdata = lg.rdata;
  assign log_count = lg.count;

  // checks
  property p_flt_latch;
    @(posedge clk) disable iff (rst) (flt_reg[0] && !rst_take) |=> flt_reg[0];
  endproperty
  a_flt_latch: assert property (p_flt_latch) else $error("fault dropped");
  property p_relay;
    @(posedge clk) disable iff (rst) (flt_raw != 8'h00) |=> !trouble_relay;
  endproperty
  a_relay: assert property (p_relay) else $error("relay not dropped");
  property p_alarm;
    @(posedge clk) disable iff (rst) (alarm_in != 8'h00) |=> alarm_tone;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not sounded");
  property p_gate;
    @(posedge clk) disable iff (rst) (reset_button && !rst_ok) |=>
      ((flt_reg & $past(flt_reg)) == $past(flt_reg));
  endproperty
  a_gate: assert property (p_gate) else $error("reset while active");
  property p_keep;
    @(posedge clk) disable iff (rst) rst_take |=>
      (alm_reg == $past(alarm_in)) && (flt_reg == $past(flt_raw));
  endproperty
  a_keep: assert property (p_keep) else $error("active alarm cleared");
  property p_tick;
    @(posedge clk) disable iff (rst) tick |=> (cyc_cnt_reg == 32'h0);
  endproperty
  a_tick: assert property (p_tick) else $error("cycle timer wrong");
  property p_wrap;
    @(posedge clk) disable iff (rst) (ls_reg == alsup_pkg::ALSUP_DONE) |=>
      (page_go == $past(tick)) && (!page_go || page_num == 4'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("run before wrap");
  property p_order;
    @(posedge clk) disable iff (rst) (page_go && page_done && pg_reg != 4'(NPAGE - 1))
      |=> pg_reg == $past(pg_reg) + 4'h1;
  endproperty
  a_order: assert property (p_order) else $error("page order");
  property p_hb;
    @(posedge clk) disable iff (rst) hb_send_a && hb_send_b;
  endproperty
  a_hb: assert property (p_hb) else $error("heartbeat off");
  property p_ring;
    @(posedge clk) disable iff (rst) (hb_echo_a && hb_echo_b) |=> !ring_flt_reg;
  endproperty
  a_ring: assert property (p_ring) else $error("ring fault stuck");
  c_reset: cover property (@(posedge clk) disable iff (rst) rst_take);
  c_wrap: cover property (@(posedge clk) disable iff (rst)
    ls_reg == alsup_pkg::ALSUP_DONE ##1 ls_reg == alsup_pkg::ALSUP_RUN);
  c_ring: cover property (@(posedge clk) disable iff (rst) ring_flt_reg);
endmodule

// ### logic/alsup_pkg.sv
// Purpose: shared constants and types for the alarm loop supervision block
// Assumes: 250 MHz clock
// Notes: times other than the ring timeout are kept in their own unit and converted to cycles here
package alsup_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned LOGIC_PERIOD_MS = 100;
  localparam int unsigned LOGIC_PERIOD_CYC = CLK_HZ / 1000 * LOGIC_PERIOD_MS;
  localparam int unsigned TIME_STAMP_PERIOD_S = 1;
  localparam int unsigned TIME_STAMP_CYC = CLK_HZ * TIME_STAMP_PERIOD_S;
  localparam int unsigned LOG_DEPTH = 4095;
  localparam int unsigned LOG_AW = 12;
  localparam int unsigned REPORT_PERIOD_S = 3;
  localparam int unsigned OFFLINE_REPORTS = 2;
  localparam int unsigned OFFLINE_CYC = CLK_HZ * REPORT_PERIOD_S * OFFLINE_REPORTS;
  localparam int unsigned RING_TIMEOUT_CYC = 1000;
  localparam int unsigned N_FAULT = 8;
  localparam int unsigned N_ALARM = 8;
  localparam int unsigned N_DEV = 8;
  localparam int unsigned N_PAGE = 16;
  localparam int unsigned EVT_W = 16;
  localparam int unsigned FLT_RING = 0;
  localparam int unsigned FLT_OFFLINE = 1;
  localparam int unsigned EVT_FAULT_TAG = 0;
  localparam int unsigned EVT_ALARM_TAG = 1;
  typedef enum logic [1:0] {
    ALSUP_IDLE = 2'b00,
    ALSUP_RUN = 2'b01,
    ALSUP_DONE = 2'b11
  } alsup_logic_state_t;
endpackage

// ### logic/alsup_log_if.sv
// Purpose: carries log write requests from the supervisor to the log memory
// Assumes: one write per cycle at most
// Notes: log answers reads one cycle late
`timescale 1ns/100ps
interface alsup_log_if;
  logic wr;
  logic [15:0] wdata;
  logic [11:0] count;
  logic [11:0] raddr;
  logic [15:0] rdata;
  modport sup (output wr, output wdata, output raddr, input count, input rdata);
  modport mem (input wr, input wdata, input raddr, output count, output rdata);
endinterface

// ### logic/alsup_log.sv
// Purpose: event log memory, fills to capacity then stops
// Assumes: caller writes at most one record per cycle
// Notes: records beyond capacity are dropped, oldest are kept
`timescale 1ns/100ps
module alsup_log #(
  parameter int unsigned DEPTH = alsup_pkg::LOG_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // log port
  alsup_log_if.mem lg
);
  logic [15:0] mem [DEPTH];
  logic [11:0] count_reg, count_next;
  logic [15:0] rdata_reg;

  // count of stored records, capped at depth
  always_comb begin
    count_next = count_reg;
    if (lg.wr && count_reg < 12'(DEPTH)) begin
      count_next = count_reg + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 12'h000;
    end else begin
      count_reg <= count_next;
    end
  end

  // memory write and registered read
  always_ff @(posedge clk) begin
    if (lg.wr && count_reg < 12'(DEPTH)) begin
      mem[count_reg] <= lg.wdata;
    end
    rdata_reg <= mem[lg.raddr];
  end

  assign lg.count = count_reg;
  assign lg.rdata = rdata_reg;

  // the log never claims more records than it can hold
  property p_cap;
    @(posedge clk) disable iff (rst) count_reg <= 12'(DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("log count over depth");
  // every accepted record below capacity advances the count by one
  property p_step;
    @(posedge clk) disable iff (rst)
      (lg.wr && count_reg < 12'(DEPTH)) |=> count_reg == $past(count_reg) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("log count did not step");
endmodule

// ### testbench/alsup_field_model.sv
// Purpose: field devices and ring wiring as seen from the supervision block
// Assumes: one report strobe per configured device each report period
// Notes: an open ring stops the echoes; cut-off devices hunt with their relays
`timescale 1ns/100ps
module alsup_field_model #(
  parameter int unsigned REPORT_CYC = 10,
  // heartbeat loss threshold and listening dwell per port
  parameter int unsigned LOSS_CYC = 4,
  parameter int unsigned DWELL_CYC = 6,
  // isolation timeout, the two hours scaled down to cycles
  parameter int unsigned ISO_TIMEOUT_CYC = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench controls
  input wire logic [7:0] dev_config,
  input wire logic [7:0] silent,
  input wire logic ring_open,
  // ring heartbeat
  input wire logic hb_send_a,
  input wire logic hb_send_b,
  output logic hb_echo_a,
  output logic hb_echo_b,
  // status reports
  output logic [7:0] dev_report,
  // isolation relays per device, high while closed
  output wire logic [7:0] relay_a,
  output wire logic [7:0] relay_b
);
  typedef enum logic [1:0] {
    ALSUP_ISO_WATCH = 2'b00,
    ALSUP_ISO_HUNT = 2'b01,
    ALSUP_ISO_HELD = 2'b11
  } alsup_iso_t;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  // report period counter
  always_comb begin
    cnt_next = (cnt_reg == 8'(REPORT_CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
  end
  always_ff @(posedge clk) begin
    cnt_reg <= rst ? 8'h00 : cnt_next;
  end
  // configured devices that are not cut off report once a period
  assign dev_report = (cnt_reg == 8'(REPORT_CYC - 1)) ? (dev_config & ~silent) : 8'h00;
  // heartbeat sent from one port returns on the other while the ring is whole
  assign hb_echo_a = hb_send_b & ~ring_open;
  assign hb_echo_b = hb_send_a & ~ring_open;
  // per-device isolation: lost heartbeat opens one port at a time
  genvar gd;
  generate
    for (gd = 0; gd < 8; gd++) begin : g_fd
      alsup_iso_t st_reg, st_next;
      logic [7:0] lc_reg, lc_next, dw_reg, dw_next, to_reg, to_next;
      logic side_reg, side_next, hunt, heard;
      // two relays, only the one on the side under test is open
      assign hunt = st_reg == ALSUP_ISO_HUNT;
      assign relay_a[gd] = !(hunt && !side_reg);
      assign relay_b[gd] = !(hunt && side_reg);
      // a device cut off on both sides hears nothing but keeps its own work going
      assign heard = ~silent[gd] &
        ((relay_a[gd] & hb_send_a) | (relay_b[gd] & hb_send_b));
      always_comb begin
        st_next = st_reg;
        side_next = side_reg;
        lc_next = heard ? 8'h00 : lc_reg + 8'h01;
        dw_next = dw_reg + 8'h01;
        to_next = to_reg + 8'h01;
        case (st_reg)
          ALSUP_ISO_WATCH: begin
            dw_next = 8'h00;
            to_next = 8'h00;
            if (!heard && lc_reg == 8'(LOSS_CYC - 1)) begin
              st_next = ALSUP_ISO_HUNT;
              side_next = 1'b0;
            end
          end
          ALSUP_ISO_HUNT: begin
            if (heard) begin
              dw_next = 8'h00;
              to_next = to_reg;
            end else if (to_reg == 8'(ISO_TIMEOUT_CYC - 1)) begin
              st_next = ALSUP_ISO_HELD;
            end else if (dw_reg == 8'(DWELL_CYC - 1)) begin
              side_next = ~side_reg;
              dw_next = 8'h00;
            end
          end
          ALSUP_ISO_HELD: begin
            if (heard) begin
              st_next = ALSUP_ISO_WATCH;
            end
          end
          default: st_next = ALSUP_ISO_WATCH;
        endcase
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          st_reg <= ALSUP_ISO_WATCH;
          side_reg <= 1'b0;
          lc_reg <= 8'h00;
          dw_reg <= 8'h00;
          to_reg <= 8'h00;
        end else begin
          st_reg <= st_next;
          side_reg <= side_next;
          lc_reg <= lc_next;
          dw_reg <= dw_next;
          to_reg <= to_next;
        end
      end
    end
  endgenerate
endmodule

// ### testbench/alsup_top_test.sv
// Purpose: self-checking bench for the alarm loop supervision block
// Assumes: periods shortened through parameters, 250 MHz clock
// Notes: the driver queues notes, a monitor checks them when due
`timescale 1ns/100ps
module alsup_top_test;
  localparam int LC = 100;
  localparam int SC = 200;
  localparam int NPG = 4;
  typedef struct {string name; int sel; logic [15:0] exp; int due;} alsup_note_t;
  logic clk, rst, reset_button, page_done, ring_open, hb_send_a, hb_send_b, hb_stamp;
  logic hb_echo_a, hb_echo_b, trouble_tone, alarm_tone, trouble_relay, page_go, cycle_start;
  logic [7:0] fault_in, alarm_in, dev_config, dev_report, silent, f, a;
  logic [7:0] fault_led, alarm_led, dev_offline, relay_a, relay_b;
  logic [3:0] page_num;
  logic [11:0] log_raddr, log_count;
  logic [15:0] log_rdata;
  alsup_note_t notes[$];
  int mismatches, checked, cyc, pexp, pwait, sc, tc, mi;
  bit idle, pd;
  alsup_top #(.LOGIC_CYC(LC), .STAMP_CYC(SC), .OFFLINE_CYC(50), .RING_CYC(20), .NPAGE(NPG)) DUT (
    .clk(clk), .rst(rst), .fault_in(fault_in), .alarm_in(alarm_in),
    .reset_button(reset_button), .hb_send_a(hb_send_a), .hb_send_b(hb_send_b),
    .hb_stamp(hb_stamp), .hb_echo_a(hb_echo_a), .hb_echo_b(hb_echo_b),
    .dev_config(dev_config), .dev_report(dev_report), .fault_led(fault_led),
    .alarm_led(alarm_led), .dev_offline(dev_offline), .trouble_tone(trouble_tone),
    .alarm_tone(alarm_tone), .trouble_relay(trouble_relay), .page_go(page_go),
    .page_num(page_num), .page_done(page_done), .cycle_start(cycle_start),
    .log_raddr(log_raddr), .log_rdata(log_rdata), .log_count(log_count));
  alsup_field_model #(.REPORT_CYC(10)) field (
    .clk(clk), .rst(rst), .dev_config(dev_config), .silent(silent), .ring_open(ring_open),
    .hb_send_a(hb_send_a), .hb_send_b(hb_send_b), .hb_echo_a(hb_echo_a),
    .hb_echo_b(hb_echo_b), .dev_report(dev_report), .relay_a(relay_a), .relay_b(relay_b));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic note(input string name, input int sel, input logic [15:0] exp, input int dly);
    alsup_note_t n;
    n = '{name, sel, exp, cyc + dly};
    notes.push_back(n);
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic press;
    reset_button = 1'b1;
    tick(1);
    reset_button = 1'b0;
  endtask
  task conclude;
    // a note still waiting at the end was never checked
    if (notes.size() > 0) mismatches++;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // selects the output that a note refers to
  function automatic logic [15:0] val(input int sel);
    case (sel)
      0: return {8'h00, fault_led};
      1: return {8'h00, alarm_led};
      2: return {8'h00, dev_offline};
      3: return {13'h0000, trouble_tone, alarm_tone, trouble_relay};
      4: return {4'h0, log_count};
      5: return {14'h0000, hb_send_a, hb_send_b};
      6: return {12'h000, page_num};
      8: return {relay_a & relay_b, relay_a | relay_b};
      default: return log_rdata;
    endcase
  endfunction
  // monitor takes due notes off the queue once the edge has settled
  always @(negedge clk) begin
    #1;
    mi = 0;
    while (mi < notes.size()) begin
      if (notes[mi].due <= cyc) begin
        cmp(notes[mi].name, notes[mi].exp, val(notes[mi].sel));
        notes.delete(mi);
      end else begin
        mi++;
      end
    end
  end
  // cycle count and hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 12000) begin
      mismatches++;
      conclude;
    end
  end
  // logic evaluator partner and period watchers
  always @(negedge clk) begin
    pd = 1'b0;
    sc++;
    tc++;
    if (cycle_start === 1'b1) begin
      if (sc > 0) cmp("cycle_period", 16'(LC), 16'(sc));
      sc = 0;
      idle = 1'b0;
    end
    if (hb_stamp === 1'b1) begin
      if (tc > 0) cmp("stamp_period", 16'(SC), 16'(tc));
      tc = 0;
    end
    if (rst === 1'b0 && page_go === 1'b1) begin
      if (idle) begin
        cmp("page_go_idle", 16'h0000, 16'h0001);
      end else if (pwait > 0) begin
        pwait--;
      end else begin
        note("page_num", 6, 16'(pexp), 0);
        pd = 1'b1;
        pexp = (pexp + 1) % NPG;
        idle = (pexp == 0);
        pwait = 30 + $urandom % 16;
      end
    end
    page_done = pd;
  end
  // main sequence
  initial begin
    fault_in = 8'h00;
    alarm_in = 8'h00;
    reset_button = 1'b0;
    page_done = 1'b0;
    ring_open = 1'b0;
    silent = 8'h00;
    dev_config = 8'hff;
    log_raddr = 12'h000;
    mismatches = 0;
    checked = 0;
    cyc = 0;
    pexp = 0;
    pwait = 0;
    sc = -100000;
    tc = -100000;
    idle = 1'b1;
    void'($urandom(82));
    rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    note("hb_send", 5, 16'h0003, 1);
    note("idle_outputs", 3, 16'h0001, 1);
    tick(4);
    f = 8'h04 | (8'($urandom) & 8'hfc);
    fault_in = f;
    note("fault_led", 0, {8'h00, f}, 1);
    note("fault_tone_relay", 3, 16'h0004, 1);
    tick(2);
    fault_in = 8'h00;
    note("fault_latched", 0, {8'h00, f}, 3);
    tick(2);
    a = 8'h01 | 8'($urandom);
    alarm_in = a;
    note("alarm_led", 1, {8'h00, a}, 1);
    note("alarm_tone", 3, 16'h0006, 1);
    tick(2);
    press;
    note("reset_refused", 0, {8'h00, f}, 2);
    tick(3);
    alarm_in = 8'h00;
    tick(2);
    press;
    note("cleared", 3, 16'h0001, 1);
    log_raddr = 12'h001;
    note("log_record", 7, {7'h00, 1'b1, a}, 1);
    note("log_count", 4, 16'h0002, 1);
    tick(2);
    ring_open = 1'b1;
    note("ring_wait", 0, 16'h0000, 16);
    note("ring_fault", 0, 16'h0001, 25);
    tick(26);
    ring_open = 1'b0;
    tick(1);
    press;
    note("ring_clear", 0, 16'h0000, 1);
    dev_config = 8'hbf;
    silent = 8'h60;
    note("offline_wait", 2, 16'h0000, 40);
    note("offline", 2, 16'h0020, 70);
    note("offline_fault", 0, 16'h0002, 70);
    note("iso_hunt", 8, 16'h9fff, 20);
    note("iso_held", 8, 16'hffff, 60);
    tick(72);
    silent = 8'h00;
    tick(12);
    press;
    note("offline_clear", 2, 16'h0000, 1);
    tick(4);
    for (int i = 0; i < 4100; i++) begin
      alarm_in = 8'h80;
      tick(1);
      alarm_in = 8'h00;
      tick(1);
    end
    log_raddr = 12'hffe;
    note("log_full", 4, 16'h0fff, 1);
    note("log_last", 7, 16'h0180, 1);
    tick(3);
    conclude;
  end
endmodule
